// >>> verilog/nfc_regs_pkg.sv
// constants, field layouts and carrier types for the collision / tx status bank
package nfc_regs_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COLL = 6'h20;
  localparam logic [IDX_W-1:0] IDX_TGT = 6'h21;
  localparam logic [IDX_W-1:0] IDX_TXH = 6'h22;
  localparam logic [IDX_W-1:0] IDX_TXL = 6'h23;
  localparam logic [IDX_W-1:0] IDX_RATE = 6'h24;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h28;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h29;

  // field positions
  localparam int COLL_BYTE_LSB = 4;
  localparam int COLL_BIT_LSB = 1;
  localparam int COLL_PAR_POS = 0;
  localparam int TXL_CNT_LSB = 3;
  localparam int RATE_LSB = 4;

  // reset values
  localparam logic [7:0] COLL_RST = 8'h00;
  localparam logic [7:0] TGT_RST = 8'h00;
  localparam logic [7:0] TXH_RST = 8'h00;
  localparam logic [7:0] TXL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [2:0] RESID_NONE = 3'h0;

  // transmit count
  localparam int TX_CNT_W = 13;
  localparam logic [12:0] TX_MAX_BYTES = 13'h1fff;

  // interrupt bits
  localparam int IRQ_N = 3;
  localparam int IRQ_COLL = 0;
  localparam int IRQ_PAR = 1;
  localparam int IRQ_FERR = 2;

  // passive target states
  typedef enum logic [3:0] {
    PT_POWER_OFF = 4'h0,
    PT_IDLE = 4'h1,
    PT_READY_L1 = 4'h2,
    PT_READY_L2 = 4'h3,
    PT_ACTIVE = 4'h5,
    PT_HALT = 4'h9,
    PT_READY_L1_STAR = 4'ha,
    PT_READY_L2_STAR = 4'hb,
    PT_ACTIVE_STAR = 4'hd
  } pt_state_type;

  // collision report from the receiver
  typedef struct packed {
    logic valid;
    logic anticoll_frame;
    logic [3:0] full_bytes;
    logic [2:0] bits;
    logic parity;
  } coll_evt_type;

  // running flags of the internal timers
  typedef struct packed {
    logic field_wait_timer_running;
    logic gp_timer_running;
    logic no_resp_timer_running;
    logic mask_rx_timer_running;
  } timer_run_type;

endpackage

// >>> verilog/irq_w1c_bank.sv
// sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/10ps
`default_nettype none
module irq_w1c_bank #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // events and software access
  input wire logic [N-1:0] i_event,
  input wire logic [N-1:0] i_clr,
  input wire logic i_mask_we,
  input wire logic [N-1:0] i_mask_wdata,
  // state
  output logic [N-1:0] o_status,
  output logic [N-1:0] o_mask,
  output logic o_irq
);
  logic [N-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;

  if (N < 1 || N > 8) $error("irq bank width out of range");

  // set beats clear so a same-cycle event is kept
  for (genvar g = 0; g < N; g++) begin : g_bit
    assign status_nxt[g] = i_event[g] | (status_r[g] & ~i_clr[g]);
  end

  always_comb begin
    mask_nxt = i_mask_we ? i_mask_wdata : mask_r;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_status = status_r;
  assign o_mask = mask_r;
  assign o_irq = irq_r;
endmodule
`default_nettype wire

// >>> verilog/tail_bit_serializer.sv
// shifts the residual bits of a split last byte out lsb first, no parity
`timescale 1ns/10ps
`default_nettype none
module tail_bit_serializer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // request
  input wire logic i_start,
  input wire logic [7:0] i_byte,
  input wire logic [2:0] i_nbits,
  // bit stream
  output logic o_bit,
  output logic o_bit_valid,
  output logic o_busy,
  output logic o_parity_en
);
  import nfc_regs_pkg::*;

  typedef enum logic {SER_IDLE = 1'b0, SER_SHIFT = 1'b1} ser_state_type;
  ser_state_type state_r, state_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] left_r, left_nxt;
  logic bit_r, bit_nxt, valid_r, valid_nxt;

  always_comb begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    left_nxt = left_r;
    bit_nxt = bit_r;
    valid_nxt = 1'b0;
    case (state_r)
      SER_IDLE: begin
        // zero residual bits means whole bytes only, nothing to shift
        if (i_start && i_nbits != RESID_NONE) begin
          bit_nxt = i_byte[0];
          valid_nxt = 1'b1;
          sh_nxt = i_byte >> 1;
          left_nxt = i_nbits - 3'h1;
          state_nxt = (i_nbits == 3'h1) ? SER_IDLE : SER_SHIFT;
        end
      end
      default: begin
        bit_nxt = sh_r[0];
        valid_nxt = 1'b1;
        sh_nxt = sh_r >> 1;
        left_nxt = left_r - 3'h1;
        if (left_r == 3'h1) begin
          state_nxt = SER_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= SER_IDLE;
      sh_r <= 8'h00;
      left_r <= 3'h0;
      bit_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      left_r <= left_nxt;
      bit_r <= bit_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_bit = bit_r;
  assign o_bit_valid = valid_r;
  assign o_busy = (state_r == SER_SHIFT);
  assign o_parity_en = 1'b0;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_lsb_first;
    (state_r == SER_IDLE && i_start && i_nbits != 3'h0) |=> (o_bit_valid && o_bit == $past(i_byte[0]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first tail bit not lsb");

  property p_no_parity;
    o_bit_valid |-> !o_parity_en;
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("parity during tail bits");

  property p_two_bits;
    (state_r == SER_IDLE && i_start && i_nbits == 3'h2) |=> o_bit_valid ##1 (o_bit_valid && o_bit == $past(i_byte[1], 2)) ##1 !o_bit_valid;
  endproperty
  a_two_bits: assert property (p_two_bits) else $error("two-bit tail wrong");

  c_four_bit_ack: cover property ((state_r == SER_IDLE && i_start && i_nbits == 3'h4) ##4 !o_busy);
endmodule
`default_nettype wire

// >>> verilog/nfc_collision_tx_status_regs.sv
// collision, target state, tx length and rate/timer status register bank
//
// Functional notes
// - bits 7:4 full bytes before collision
// - bits 3:1 bits before collision in byte
// - bit 0 flags collision on parity bit
// - update only for anticollision command frames
// - fields invalid while hard framing flag set
// - target state bits 3:0 coded state
// - 13-bit byte count split over two registers
// - bits 2:0 residual bits, zero whole bytes
// - partial byte sent lsb first
// - residual bits sent without parity
// - parity irq on reqa/wupa with residual
// - bits 5:4 detected bit rate, 7:6 zero
// - bits 3:0 show timers running
// - framing error sets hard framing flag
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module nfc_collision_tx_status_regs (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // avalon-mm slave
  input wire logic [nfc_regs_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [nfc_regs_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [nfc_regs_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // receiver and state machine status
  input wire nfc_regs_pkg::coll_evt_type i_coll_evt,
  input wire logic i_framing_error,
  input wire logic [3:0] i_target_state,
  input wire logic [1:0] i_nfc_rate,
  input wire nfc_regs_pkg::timer_run_type i_timers,
  // anticollision command context
  input wire logic i_anticoll_ctl,
  input wire logic i_card_idle,
  input wire logic i_reqa_wupa_cmd,
  // residual byte request from the framer
  input wire logic i_tail_start,
  input wire logic [7:0] i_tail_byte,
  // transmit length
  output logic [nfc_regs_pkg::TX_CNT_W-1:0] o_tx_byte_count,
  output logic [2:0] o_tx_residual_bits,
  // flags and interrupt
  output logic o_hard_framing_error_flag,
  output logic o_irq,
  // residual bit stream
  output logic o_tail_bit,
  output logic o_tail_bit_valid,
  output logic o_tail_busy,
  output logic o_tail_parity_en
);
  import nfc_regs_pkg::*;

  if (TX_CNT_W != 13) $error("tx count must be 13 bits");
  if (IRQ_N > 8) $error("irq bits must fit one byte");

  // bus handshake
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic req;
  logic accept_wr;
  logic [IDX_W-1:0] idx;
  logic [7:0] rd_mux;

  // register state
  logic [7:0] coll_r, coll_nxt;
  logic [7:0] tgt_r, tgt_nxt;
  logic [7:0] txh_r, txh_nxt;
  logic [7:0] txl_r, txl_nxt;
  logic [7:0] rate_r, rate_nxt;

  // interrupt bank hookup
  logic [IRQ_N-1:0] irq_event;
  logic [IRQ_N-1:0] irq_clr;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic irq_mask_we;
  logic coll_take;
  logic par_event;

  assign req = i_avs_read | i_avs_write;
  assign idx = i_avs_address[ADDR_W-1:2];
  // only the low byte lane carries data; other lanes are don't-care
  assign accept_wr = i_avs_write & ~wait_r & i_avs_byteenable[0];

  // one wait cycle per access, answer on the next edge
  always_comb begin
    wait_nxt = 1'b1;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
    end
  end

  // read multiplexer; unmapped indices read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (idx == IDX_COLL) begin
      rd_mux = coll_r;
    end else if (idx == IDX_TGT) begin
      rd_mux = tgt_r;
    end else if (idx == IDX_TXH) begin
      rd_mux = txh_r;
    end else if (idx == IDX_TXL) begin
      rd_mux = txl_r;
    end else if (idx == IDX_RATE) begin
      rd_mux = rate_r;
    end else if (idx == IDX_IRQ_STAT) begin
      rd_mux = {{(8-IRQ_N){1'b0}}, irq_status};
    end else if (idx == IDX_IRQ_MASK) begin
      rd_mux = {{(8-IRQ_N){1'b0}}, irq_mask};
    end
  end

  // read data loaded while waitrequest is still high, stable at the answer edge
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_avs_read && wait_r) begin
      rdata_nxt = {24'h000000, rd_mux};
    end
  end

  // collision capture
  always_comb begin
    coll_take = i_coll_evt.valid & i_coll_evt.anticoll_frame;
    coll_nxt = coll_r;
    if (coll_take) begin
      coll_nxt[7:COLL_BYTE_LSB] = i_coll_evt.full_bytes;
      coll_nxt[COLL_BYTE_LSB-1:COLL_BIT_LSB] = i_coll_evt.bits;
      coll_nxt[COLL_PAR_POS] = i_coll_evt.parity;
    end
  end

  // live status views; host writes never reach them
  always_comb begin
    tgt_nxt = {4'h0, i_target_state};
    rate_nxt = 8'h00;
    rate_nxt[RATE_LSB+1:RATE_LSB] = i_nfc_rate;
    rate_nxt[3] = i_timers.field_wait_timer_running;
    rate_nxt[2] = i_timers.gp_timer_running;
    rate_nxt[1] = i_timers.no_resp_timer_running;
    rate_nxt[0] = i_timers.mask_rx_timer_running;
  end

  // transmit length registers
  always_comb begin
    txh_nxt = txh_r;
    txl_nxt = txl_r;
    if (accept_wr && idx == IDX_TXH) begin
      txh_nxt = i_avs_writedata[7:0];
    end else if (accept_wr && idx == IDX_TXL) begin
      txl_nxt = i_avs_writedata[7:0];
    end
  end

  // interrupt events and software access
  always_comb begin
    par_event = i_anticoll_ctl & i_card_idle & i_reqa_wupa_cmd
                & (txl_r[2:0] != RESID_NONE);
    irq_event = '0;
    irq_event[IRQ_COLL] = coll_take;
    irq_event[IRQ_PAR] = par_event;
    irq_event[IRQ_FERR] = i_framing_error;
    irq_clr = '0;
    if (accept_wr && idx == IDX_IRQ_STAT) begin
      irq_clr = i_avs_writedata[IRQ_N-1:0];
    end
    irq_mask_we = accept_wr && idx == IDX_IRQ_MASK;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      coll_r <= COLL_RST;
      tgt_r <= TGT_RST;
      txh_r <= TXH_RST;
      txl_r <= TXL_RST;
      rate_r <= RATE_RST;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      coll_r <= coll_nxt;
      tgt_r <= tgt_nxt;
      txh_r <= txh_nxt;
      txl_r <= txl_nxt;
      rate_r <= rate_nxt;
    end
  end

  irq_w1c_bank #(
    .N(IRQ_N)
  ) u_irq (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(irq_event),
    .i_clr(irq_clr),
    .i_mask_we(irq_mask_we),
    .i_mask_wdata(i_avs_writedata[IRQ_N-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // residual bits go out of the last byte's low end
  tail_bit_serializer u_tail (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(i_tail_start),
    .i_byte(i_tail_byte),
    .i_nbits(txl_r[2:0]),
    .o_bit(o_tail_bit),
    .o_bit_valid(o_tail_bit_valid),
    .o_busy(o_tail_busy),
    .o_parity_en(o_tail_parity_en)
  );

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;
  assign o_tx_byte_count = {txh_r, txl_r[7:TXL_CNT_LSB]};
  assign o_tx_residual_bits = txl_r[2:0];
  // collision fields are junk while this is set; software must check it first
  assign o_hard_framing_error_flag = irq_status[IRQ_FERR];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_coll_bytes;
    coll_take |=> coll_r[7:4] == $past(i_coll_evt.full_bytes);
  endproperty
  a_coll_bytes: assert property (p_coll_bytes) else $error("collision byte count wrong");

  property p_coll_bits;
    coll_take |=> coll_r[3:1] == $past(i_coll_evt.bits);
  endproperty
  a_coll_bits: assert property (p_coll_bits) else $error("collision bit count wrong");

  property p_coll_par;
    coll_take |=> coll_r[0] == $past(i_coll_evt.parity);
  endproperty
  a_coll_par: assert property (p_coll_par) else $error("parity collision flag wrong");

  property p_coll_long_msg;
    (i_coll_evt.valid && !i_coll_evt.anticoll_frame) |=> $stable(coll_r);
  endproperty
  a_coll_long_msg: assert property (p_coll_long_msg) else $error("long frame changed collision");

  property p_ferr_flag;
    i_framing_error |=> o_hard_framing_error_flag;
  endproperty
  a_ferr_flag: assert property (p_ferr_flag) else $error("framing flag not set");

  property p_tgt_view;
    !i_sys_rst |=> tgt_r == {4'h0, $past(i_target_state)};
  endproperty
  a_tgt_view: assert property (p_tgt_view) else $error("target state view wrong");

  property p_tx_high;
    (accept_wr && idx == IDX_TXH) |=> o_tx_byte_count[12:5] == $past(i_avs_writedata[7:0]);
  endproperty
  a_tx_high: assert property (p_tx_high) else $error("tx count high bits wrong");

  property p_tx_low;
    (accept_wr && idx == IDX_TXL) |=>
      (o_tx_byte_count[4:0] == $past(i_avs_writedata[7:3])
       && o_tx_residual_bits == $past(i_avs_writedata[2:0]));
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("tx count low bits wrong");

  property p_par_irq;
    (i_anticoll_ctl && i_card_idle && i_reqa_wupa_cmd && txl_r[2:0] != 3'h0)
      |=> irq_status[IRQ_PAR];
  endproperty
  a_par_irq: assert property (p_par_irq) else $error("parity irq missing");

  property p_rate_view;
    !i_sys_rst |=> (rate_r[7:6] == 2'h0 && rate_r[5:4] == $past(i_nfc_rate));
  endproperty
  a_rate_view: assert property (p_rate_view) else $error("bit rate view wrong");

  property p_timer_view;
    !i_sys_rst |=> rate_r[3:0] == $past(i_timers);
  endproperty
  a_timer_view: assert property (p_timer_view) else $error("timer view wrong");

  property p_ro_write;
    (accept_wr && idx == IDX_COLL && !coll_take) |=> $stable(coll_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write reached collision view");

  property p_bus_answer;
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

  property p_irq_level;
    |(irq_status & irq_mask) |-> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq low with unmasked status");

  c_coll_capture: cover property (coll_take ##1 (i_avs_read && idx == IDX_COLL));
  c_par_irq: cover property (par_event ##1 o_irq);
  c_tx_write: cover property ((accept_wr && idx == IDX_TXH) ##[1:4] (accept_wr && idx == IDX_TXL));
endmodule
`default_nettype wire

// >>> tb/nfc_host_model.sv
// host-side avalon-mm master model for the collision / tx status bank
`timescale 1ns/10ps
`default_nettype none
module nfc_host_model (
  // clock
  input wire logic i_core_clk,
  // avalon-mm master side
  output logic [nfc_regs_pkg::ADDR_W-1:0] o_avs_address,
  output logic o_avs_read,
  output logic o_avs_write,
  output logic [nfc_regs_pkg::DATA_W-1:0] o_avs_writedata,
  output logic [3:0] o_avs_byteenable,
  input wire logic [nfc_regs_pkg::DATA_W-1:0] i_avs_readdata,
  input wire logic i_avs_waitrequest
);
  import nfc_regs_pkg::*;
  initial begin
    o_avs_address = 8'h00;
    o_avs_read = 1'b0;
    o_avs_write = 1'b0;
    o_avs_writedata = 32'h0;
    o_avs_byteenable = 4'h0;
  end
  // request held until the edge that sees waitrequest low
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_avs_address <= a;
    o_avs_read <= ~wr;
    o_avs_write <= wr;
    o_avs_writedata <= {24'h0, d};
    o_avs_byteenable <= be;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_avs_waitrequest !== 1'b0 && n < 16);
    rd = i_avs_readdata;
    o_avs_read <= 1'b0;
    o_avs_write <= 1'b0;
    // released lines show junk, not the last value
    o_avs_address <= ~a;
    o_avs_writedata <= ~{24'h0, d};
    if (n >= 16) begin
      nfc_collision_tx_status_regs_bench.fails++;
      nfc_collision_tx_status_regs_bench.finish_test();
    end
  endtask
  // count split over two registers, never above the 13-bit limit
  task automatic set_tx_count(input logic [12:0] n, input logic [2:0] r);
    logic [31:0] x;
    access(1'b1, 8'h88, n[12:5], 4'h1, x);
    // a nonzero residual is only set for frames sent without crc
    access(1'b1, 8'h8c, {n[4:0], r}, 4'h1, x);
  endtask
  // in active or active* every received command is the host's job
  task automatic read_target(output logic [31:0] rd, output logic act);
    access(1'b0, 8'h84, 8'h00, 4'h1, rd);
    act = (rd[3:0] == PT_ACTIVE) || (rd[3:0] == PT_ACTIVE_STAR);
  endtask
  // collision fields are only trusted while the hard framing flag is clear
  task automatic read_coll(input logic ferr, output logic [31:0] rd);
    access(1'b0, 8'h80, 8'h00, 4'h1, rd);
    if (ferr)
      rd = 32'h0;
  endtask
endmodule
`default_nettype wire

// >>> tb/nfc_collision_tx_status_regs_bench.sv
// self-checking bench for the collision / tx status register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module nfc_collision_tx_status_regs_bench;
  import nfc_regs_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] be;
    logic [7:0] exp;
  } row_type;
  localparam row_type ROWS [20] = '{
    '{1'b0, 8'h80, 8'h00, 4'h1, 8'h00}, '{1'b0, 8'h84, 8'h00, 4'h1, 8'h00},
    '{1'b0, 8'h88, 8'h00, 4'h1, 8'h00}, '{1'b0, 8'h8c, 8'h00, 4'h1, 8'h00},
    '{1'b0, 8'h90, 8'h00, 4'h1, 8'h00}, '{1'b0, 8'ha0, 8'h00, 4'h1, 8'h00},
    '{1'b0, 8'ha4, 8'h00, 4'h1, 8'h00}, '{1'b1, 8'h88, 8'ha5, 4'h1, 8'h00},
    '{1'b0, 8'h88, 8'h00, 4'h1, 8'ha5}, '{1'b1, 8'h88, 8'h3c, 4'he, 8'h00},
    '{1'b0, 8'h8b, 8'h00, 4'h1, 8'ha5}, '{1'b1, 8'h80, 8'hff, 4'h1, 8'h00},
    '{1'b0, 8'h80, 8'h00, 4'h1, 8'h00}, '{1'b1, 8'h84, 8'hff, 4'h1, 8'h00},
    '{1'b0, 8'h84, 8'h00, 4'h1, 8'h00}, '{1'b1, 8'h90, 8'hff, 4'h1, 8'h00},
    '{1'b0, 8'h90, 8'h00, 4'h1, 8'h00}, '{1'b1, 8'hfc, 8'hff, 4'h1, 8'h00},
    '{1'b0, 8'hfc, 8'h00, 4'h1, 8'h00}, '{1'b0, 8'h8c, 8'h00, 4'h1, 8'h00}};
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd};
  int fails = 0;
  int n_checks = 0;
  logic i_core_clk, i_sys_rst, i_framing_error, i_anticoll_ctl, i_card_idle;
  logic i_reqa_wupa_cmd, i_tail_start;
  logic [3:0] i_target_state;
  logic [1:0] i_nfc_rate;
  logic [7:0] i_tail_byte;
  coll_evt_type i_coll_evt;
  timer_run_type i_timers;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] avs_byteenable;
  logic [12:0] tx_count;
  logic [2:0] tx_resid;
  logic ferr_flag, irq, tail_bit, tail_valid, tail_busy, tail_par;
  int cnt, nbusy;
  logic [7:0] bits;
  logic par_seen, active;
  nfc_collision_tx_status_regs u_nfc_collision_tx_status_regs (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_coll_evt(i_coll_evt), .i_framing_error(i_framing_error),
    .i_target_state(i_target_state), .i_nfc_rate(i_nfc_rate), .i_timers(i_timers),
    .i_anticoll_ctl(i_anticoll_ctl), .i_card_idle(i_card_idle),
    .i_reqa_wupa_cmd(i_reqa_wupa_cmd), .i_tail_start(i_tail_start),
    .i_tail_byte(i_tail_byte), .o_tx_byte_count(tx_count), .o_tx_residual_bits(tx_resid),
    .o_hard_framing_error_flag(ferr_flag), .o_irq(irq), .o_tail_bit(tail_bit),
    .o_tail_bit_valid(tail_valid), .o_tail_busy(tail_busy), .o_tail_parity_en(tail_par));
  nfc_host_model u_nfc_host_model (
    .i_core_clk(i_core_clk), .o_avs_address(avs_address), .o_avs_read(avs_read),
    .o_avs_write(avs_write), .o_avs_writedata(avs_writedata),
    .o_avs_byteenable(avs_byteenable), .i_avs_readdata(avs_readdata),
    .i_avs_waitrequest(avs_waitrequest));
  always #5 i_core_clk = ~i_core_clk;
  task automatic finish_test();
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_nfc_host_model.access(1'b1, a, d, 4'h1, x);
  endtask
  task automatic rd8(input logic [7:0] a);
    u_nfc_host_model.access(1'b0, a, 8'h00, 4'h1, rdata);
  endtask
  // let the edge's updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic pulse_reqa();
    @(posedge i_core_clk);
    i_reqa_wupa_cmd <= 1'b1;
    @(posedge i_core_clk);
    i_reqa_wupa_cmd <= 1'b0;
    settle(2);
  endtask
  // gathers each valid bit once, first out lands in bit 0
  task automatic tail_run(input logic [7:0] b);
    cnt = 0;
    nbusy = 0;
    bits = 8'h00;
    par_seen = 1'b0;
    @(posedge i_core_clk);
    i_tail_byte <= b;
    i_tail_start <= 1'b1;
    @(posedge i_core_clk);
    i_tail_start <= 1'b0;
    repeat (12) begin
      #1;
      if (tail_valid === 1'b1 && cnt < 8) begin
        bits[cnt] = tail_bit;
        cnt++;
      end
      par_seen = par_seen | (tail_par !== 1'b0);
      if (tail_busy === 1'b1)
        nbusy++;
      @(posedge i_core_clk);
    end
  endtask
  initial begin
    i_core_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_coll_evt = '0;
    i_framing_error = 1'b0;
    i_target_state = 4'h0;
    i_nfc_rate = 2'h0;
    i_timers = '0;
    i_anticoll_ctl = 1'b0;
    i_card_idle = 1'b0;
    i_reqa_wupa_cmd = 1'b0;
    i_tail_start = 1'b0;
    i_tail_byte = 8'h00;
    repeat (20) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr)
        u_nfc_host_model.access(1'b1, ROWS[i].addr, ROWS[i].data, ROWS[i].be, rdata);
      else begin
        rd8(ROWS[i].addr);
        `CHK(rdata, {24'h0, ROWS[i].exp})
      end
    end
    foreach (codes[i]) begin
      @(posedge i_core_clk);
      i_target_state <= codes[i];
      u_nfc_host_model.read_target(rdata, active);
      `CHK(rdata, {28'h0, codes[i]})
      `CHK(active, (codes[i] == 4'h5 || codes[i] == 4'hd))
    end
    @(posedge i_core_clk);
    i_nfc_rate <= 2'h2;
    i_timers <= 4'ha;
    rd8(8'h90);
    `CHK(rdata, 32'h2a)
    @(posedge i_core_clk);
    i_nfc_rate <= 2'h1;
    i_timers <= 4'h5;
    rd8(8'h90);
    `CHK(rdata, 32'h15)
    u_nfc_host_model.set_tx_count(13'h1fff, 3'h0);
    settle(1);
    `CHK(tx_count, 13'h1fff)
    `CHK(tx_resid, 3'h0)
    tail_run(8'hb6);
    `CHK(cnt, 0)
    `CHK(nbusy, 0)
    i_anticoll_ctl <= 1'b1;
    i_card_idle <= 1'b1;
    pulse_reqa();
    rd8(8'ha0);
    `CHK(rdata, 32'h0)
    u_nfc_host_model.set_tx_count(13'h0001, 3'h4);
    settle(1);
    `CHK(tx_resid, 3'h4)
    tail_run(8'hb6);
    `CHK(cnt, 4)
    `CHK(nbusy, 3)
    `CHK(bits, 8'h06)
    `CHK(par_seen, 1'b0)
    pulse_reqa();
    rd8(8'ha0);
    `CHK(rdata, 32'h2)
    wr8(8'ha0, 8'h02);
    i_card_idle <= 1'b0;
    pulse_reqa();
    rd8(8'ha0);
    `CHK(rdata, 32'h0)
    wr8(8'ha4, 8'h07);
    @(posedge i_core_clk);
    i_coll_evt <= '{1'b1, 1'b1, 4'h9, 3'h5, 1'b1};
    @(posedge i_core_clk);
    i_coll_evt <= '{1'b1, 1'b0, 4'h2, 3'h2, 1'b0};
    @(posedge i_core_clk);
    i_coll_evt <= '0;
    settle(2);
    `CHK(irq, 1'b1)
    u_nfc_host_model.read_coll(ferr_flag, rdata);
    `CHK(rdata, 32'h9b)
    wr8(8'ha0, 8'h01);
    settle(1);
    `CHK(irq, 1'b0)
    wr8(8'ha4, 8'h00);
    @(posedge i_core_clk);
    i_framing_error <= 1'b1;
    @(posedge i_core_clk);
    i_framing_error <= 1'b0;
    settle(2);
    `CHK(ferr_flag, 1'b1)
    `CHK(irq, 1'b0)
    wr8(8'ha0, 8'h04);
    settle(1);
    `CHK(ferr_flag, 1'b0)
    u_nfc_host_model.set_tx_count(13'h0002, 3'h2);
    tail_run(8'h02);
    `CHK(cnt, 2)
    `CHK(bits, 8'h02)
    `CHK(nbusy, 1)
    // mid-run reset drops every register back to its default
    u_nfc_host_model.set_tx_count(13'h0155, 3'h3);
    wr8(8'ha4, 8'h07);
    @(posedge i_core_clk);
    i_framing_error <= 1'b1;
    @(posedge i_core_clk);
    i_framing_error <= 1'b0;
    i_sys_rst <= 1'b1;
    settle(2);
    `CHK(tx_count, 13'h0000)
    `CHK(tx_resid, 3'h0)
    `CHK(ferr_flag, 1'b0)
    `CHK(irq, 1'b0)
    @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd8(8'h8c);
    `CHK(rdata, 32'h0)
    rd8(8'h84);
    `CHK(rdata, 32'h0000000d)
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
